// *** branch_operand_pkg.sv ***
// Constants and types for the branch target and operand address decoder
`default_nettype none
package branch_operand_pkg;
    localparam logic [15:0] PC_RESET          = 16'h0000;
    localparam logic [15:0] FIXED_AREA_BASE   = 16'h0800;
    localparam logic [15:0] TABLE_BASE        = 16'h0040;
    localparam logic [15:0] EXT_AREA_LO       = 16'hFFD0;
    localparam logic [15:0] EXT_AREA_HI       = 16'hFFDF;
    localparam logic [15:0] SFR_PAGE          = 16'hFF00;
    localparam int          TABLE_FIELD_LSB   = 1;
    localparam int          TABLE_FIELD_MSB   = 5;
    localparam int          DISP_SIGN_BIT     = 7;
    localparam logic [2:0]  CODE_X = 3'h0;
    localparam logic [2:0]  CODE_A = 3'h1;
    localparam logic [1:0]  PAIR_AX = 2'h0;

    typedef enum logic [3:0] {
        OP_SEQ        = 4'h0,
        OP_REL        = 4'h1,
        OP_ABS16      = 4'h2,
        OP_FIXED_CALL = 4'h3,
        OP_TABLE_CALL = 4'h4,
        OP_REG_JUMP   = 4'h5,
        OP_MULTIPLY   = 4'h6,
        OP_DIVIDE     = 4'h7,
        OP_DEC_ADJUST = 4'h8,
        OP_DIGIT_ROT  = 4'h9,
        OP_REG_BYTE   = 4'hA,
        OP_REG_PAIR   = 4'hB,
        OP_SFR        = 4'hC
    } op_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE       = 2'b00,
        ST_TABLE_WAIT = 2'b01,
        ST_TABLE_LOAD = 2'b11
    } state_t;
endpackage
`default_nettype wire

// *** table_memory.sv ***
// Branch address table memory with registered read data
`default_nettype none
module table_memory (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_index,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_en,
    input  wire logic [4:0]  rd_index,
    output var  logic [15:0] rd_data
);
    logic [15:0] entry_mem [0:31];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            entry_mem[wr_index] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= entry_mem[rd_index];
        end
    end
endmodule // table_memory
`default_nettype wire

// *** branch_operand_addressing.sv ***
// Next program counter and operand register / address selection
`default_nettype none
module branch_operand_addressing (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instr_valid,
    input  wire logic [3:0]  op_kind,
    input  wire logic [2:0]  instr_length,
    input  wire logic        branch_taken,
    input  wire logic [7:0]  relative_displacement,
    input  wire logic [15:0] immediate_addr,
    input  wire logic [7:0]  opcode,
    input  wire logic [15:0] accumulator_pair,
    input  wire logic        bank_select_low,
    input  wire logic        bank_select_high,
    input  wire logic [2:0]  byte_register_code,
    input  wire logic [1:0]  pair_register_code,
    input  wire logic [7:0]  sfr_offset,
    input  wire logic        table_wr_en,
    input  wire logic [4:0]  table_wr_index,
    input  wire logic [15:0] table_wr_data,
    output var  logic [15:0] program_counter,
    output var  logic        busy,
    output var  logic        pc_loaded,
    output var  logic [4:0]  src_reg_index,
    output var  logic [4:0]  dst_reg_index,
    output var  logic        dst_is_pair,
    output var  logic [15:0] sfr_address,
    output var  logic        sfr_address_valid,
    output var  logic        sfr_address_fault
);
    branch_operand_pkg::state_t state_reg;
    branch_operand_pkg::state_t state_next;
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic        loaded_reg;
    logic [15:0] seq_pc;
    logic [15:0] rel_pc;
    logic [15:0] fixed_pc;
    logic [4:0]  table_index;
    logic [15:0] table_data;
    logic        table_rd;
    logic [1:0]  bank;
    logic [15:0] sfr_addr_comb;
    logic        sfr_ext_hit;
    branch_operand_pkg::op_kind_t kind;

    // Register file index: bank in the upper bits, byte code below
    function automatic logic [4:0] byte_index(input logic [1:0] b, input logic [2:0] code);
        byte_index = {b, code};
    endfunction

    // Pair code n names bytes 2n (low) and 2n+1 (high), so AX,BC,DE,HL
    function automatic logic [4:0] pair_index(input logic [1:0] b, input logic [1:0] code);
        pair_index = {b, code, 1'b0};
    endfunction

    assign kind  = branch_operand_pkg::op_kind_t'(op_kind);
    assign bank  = {bank_select_high, bank_select_low};
    // Byte length is at most seven, so carry past bit 15 just wraps
    assign seq_pc = pc_reg + {13'h0000, instr_length};
    // Sum is cut to 16 bits so a branch across the top wraps
    assign rel_pc = seq_pc + {{8{relative_displacement[branch_operand_pkg::DISP_SIGN_BIT]}},
                              relative_displacement};
    assign fixed_pc = branch_operand_pkg::FIXED_AREA_BASE
                    | {5'h00, immediate_addr[10:0]};
    assign table_index = opcode[branch_operand_pkg::TABLE_FIELD_MSB:
                                branch_operand_pkg::TABLE_FIELD_LSB];
    assign table_rd = instr_valid && (state_reg == branch_operand_pkg::ST_IDLE)
                   && (kind == branch_operand_pkg::OP_TABLE_CALL);

    // Table slots are the words at 40H..7FH; slot i lives at 40H + 2i
    table_memory u_table (
        .clk      (clk),
        .wr_en    (table_wr_en),
        .wr_index (table_wr_index),
        .wr_data  (table_wr_data),
        .rd_en    (table_rd),
        .rd_index (table_index),
        .rd_data  (table_data)
    );

    assign sfr_addr_comb = branch_operand_pkg::SFR_PAGE | {8'h00, sfr_offset};
    assign sfr_ext_hit = (sfr_addr_comb >= branch_operand_pkg::EXT_AREA_LO)
                      && (sfr_addr_comb <= branch_operand_pkg::EXT_AREA_HI);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            branch_operand_pkg::ST_IDLE: begin
                if (table_rd) begin
                    state_next = branch_operand_pkg::ST_TABLE_WAIT;
                end
            end
            branch_operand_pkg::ST_TABLE_WAIT: begin
                state_next = branch_operand_pkg::ST_TABLE_LOAD;
            end
            branch_operand_pkg::ST_TABLE_LOAD: begin
                state_next = branch_operand_pkg::ST_IDLE;
            end
            default: begin
                state_next = branch_operand_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        pc_next = pc_reg;
        if (state_reg == branch_operand_pkg::ST_TABLE_LOAD) begin
            pc_next = table_data;
        end else if (instr_valid && state_reg == branch_operand_pkg::ST_IDLE) begin
            case (kind)
                branch_operand_pkg::OP_REL: begin
                    pc_next = branch_taken ? rel_pc : seq_pc;
                end
                branch_operand_pkg::OP_ABS16: begin
                    pc_next = immediate_addr;
                end
                branch_operand_pkg::OP_FIXED_CALL: begin
                    pc_next = fixed_pc;
                end
                branch_operand_pkg::OP_TABLE_CALL: begin
                    pc_next = pc_reg;
                end
                branch_operand_pkg::OP_REG_JUMP: begin
                    pc_next = accumulator_pair;
                end
                default: begin
                    pc_next = seq_pc;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= branch_operand_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc_reg     <= branch_operand_pkg::PC_RESET;
            loaded_reg <= 1'b0;
        end else begin
            pc_reg     <= pc_next;
            loaded_reg <= (state_reg == branch_operand_pkg::ST_TABLE_LOAD)
                       || (instr_valid && !table_rd
                           && state_reg == branch_operand_pkg::ST_IDLE);
        end
    end

    assign program_counter = pc_reg;
    assign pc_loaded       = loaded_reg;
    // Both wait states carry bit 0 set, so busy is a flop bit and needs no decode
    assign busy            = state_reg[0];

    // Operand register selection, registered toward the datapath
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            src_reg_index <= 5'h00;
            dst_reg_index <= 5'h00;
            dst_is_pair   <= 1'b0;
        end else if (instr_valid && state_reg == branch_operand_pkg::ST_IDLE) begin
            case (kind)
                branch_operand_pkg::OP_MULTIPLY: begin
                    src_reg_index <= byte_index(bank, branch_operand_pkg::CODE_A);
                    dst_reg_index <= pair_index(bank, branch_operand_pkg::PAIR_AX);
                    dst_is_pair   <= 1'b1;
                end
                branch_operand_pkg::OP_DIVIDE: begin
                    src_reg_index <= pair_index(bank, branch_operand_pkg::PAIR_AX);
                    dst_reg_index <= pair_index(bank, branch_operand_pkg::PAIR_AX);
                    dst_is_pair   <= 1'b1;
                end
                branch_operand_pkg::OP_DEC_ADJUST: begin
                    src_reg_index <= byte_index(bank, branch_operand_pkg::CODE_A);
                    dst_reg_index <= byte_index(bank, branch_operand_pkg::CODE_A);
                    dst_is_pair   <= 1'b0;
                end
                branch_operand_pkg::OP_DIGIT_ROT: begin
                    src_reg_index <= byte_index(bank, branch_operand_pkg::CODE_A);
                    dst_reg_index <= byte_index(bank, branch_operand_pkg::CODE_A);
                    dst_is_pair   <= 1'b0;
                end
                branch_operand_pkg::OP_REG_BYTE: begin
                    src_reg_index <= byte_index(bank, byte_register_code);
                    dst_reg_index <= byte_index(bank, byte_register_code);
                    dst_is_pair   <= 1'b0;
                end
                branch_operand_pkg::OP_REG_PAIR: begin
                    src_reg_index <= pair_index(bank, pair_register_code);
                    dst_reg_index <= pair_index(bank, pair_register_code);
                    dst_is_pair   <= 1'b1;
                end
                default: begin
                    src_reg_index <= src_reg_index;
                    dst_reg_index <= dst_reg_index;
                    dst_is_pair   <= dst_is_pair;
                end
            endcase
        end
    end

    // Short register form; an external window address is loaded but flagged as a fault, with valid held low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sfr_address       <= 16'h0000;
            sfr_address_valid <= 1'b0;
            sfr_address_fault <= 1'b0;
        end else begin
            sfr_address_valid <= 1'b0;
            sfr_address_fault <= 1'b0;
            if (instr_valid && state_reg == branch_operand_pkg::ST_IDLE
                && kind == branch_operand_pkg::OP_SFR) begin
                sfr_address       <= sfr_addr_comb;
                sfr_address_valid <= !sfr_ext_hit;
                sfr_address_fault <= sfr_ext_hit;
            end
        end
    end
endmodule // branch_operand_addressing
`default_nettype wire

// *** branch_operand_addressing_checker.sv ***
// Concurrent checks on the branch target and operand decoder ports
`default_nettype none
module branch_operand_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        instr_valid,
    input wire logic [3:0]  op_kind,
    input wire logic [2:0]  instr_length,
    input wire logic        branch_taken,
    input wire logic [7:0]  relative_displacement,
    input wire logic [15:0] immediate_addr,
    input wire logic [15:0] accumulator_pair,
    input wire logic        bank_select_low,
    input wire logic        bank_select_high,
    input wire logic [2:0]  byte_register_code,
    input wire logic [1:0]  pair_register_code,
    input wire logic [7:0]  sfr_offset,
    input wire logic [15:0] program_counter,
    input wire logic        busy,
    input wire logic        pc_loaded,
    input wire logic [4:0]  dst_reg_index,
    input wire logic        dst_is_pair,
    input wire logic [15:0] sfr_address,
    input wire logic        sfr_address_valid,
    input wire logic        sfr_address_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        take;
    logic [15:0] disp_ext;
    logic [4:0]  byte_idx;
    logic [4:0]  pair_idx;
    assign take = instr_valid && !busy;
    assign disp_ext = {{8{relative_displacement[7]}}, relative_displacement};
    assign byte_idx = {bank_select_high, bank_select_low, byte_register_code};
    assign pair_idx = {bank_select_high, bank_select_low, pair_register_code, 1'b0};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Reset itself is the cause here, so this one is not disabled by it
    a_reset_clears: assert property (disable iff (1'b0) !reset_n |=> program_counter == 16'h0000
        && !busy && !pc_loaded) else $error("state not cleared by reset");
    a_seq_advance: assert property (take && op_kind == 4'h0 |=> program_counter ==
        $past(program_counter) + $past(instr_length)) else $error("bad sequential pc");
    a_rel_target: assert property (take && op_kind == 4'h1 |=> program_counter ==
        $past(program_counter) + $past(instr_length) + ($past(branch_taken) ? $past(disp_ext)
        : 16'h0000)) else $error("bad relative target");
    a_abs_load: assert property (take && op_kind == 4'h2 |=> program_counter ==
        $past(immediate_addr)) else $error("bad absolute target");
    a_fixed_area: assert property (take && op_kind == 4'h3 |=> program_counter[15:11] == 5'h01
        && program_counter[10:0] == $past(immediate_addr[10:0])) else $error("bad fixed call");
    a_reg_jump: assert property (take && op_kind == 4'h5 |=> program_counter ==
        $past(accumulator_pair)) else $error("bad register jump");
    a_table_walk: assert property (take && op_kind == 4'h4 |=> busy [*2] ##1 (!busy && pc_loaded))
        else $error("bad table call timing");
    a_sfr_refused: assert property (take && op_kind == 4'hC && sfr_offset[7:4] == 4'hD |=>
        sfr_address_fault && !sfr_address_valid) else $error("external area reached");
    a_sfr_mapped: assert property (take && op_kind == 4'hC && sfr_offset[7:4] != 4'hD |=>
        sfr_address_valid && sfr_address == {8'hFF, $past(sfr_offset)})
        else $error("bad short register address");
    a_byte_select: assert property (take && op_kind == 4'hA |=> !dst_is_pair &&
        dst_reg_index == $past(byte_idx)) else $error("bad byte register");
    a_pair_select: assert property (take && op_kind == 4'hB |=> dst_is_pair &&
        dst_reg_index == $past(pair_idx)) else $error("bad register pair");
    c_table_call: cover property (take && op_kind == 4'h4);
    c_rel_back: cover property (take && op_kind == 4'h1 && branch_taken && disp_ext[15]);
    c_sfr_fault: cover property (sfr_address_fault);
endmodule // branch_operand_checker
bind branch_operand_addressing branch_operand_checker chk (.*);
`default_nettype wire

// *** branch_operand_addressing_tb.sv ***
// Self-checking testbench for the branch target and operand decoder
`default_nettype none
module branch_operand_addressing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, instr_valid, branch_taken, table_wr_en, busy, pc_loaded;
    logic        bank_select_low, bank_select_high, dst_is_pair;
    logic        sfr_address_valid, sfr_address_fault;
    logic [3:0]  op_kind;
    logic [2:0]  instr_length, byte_register_code;
    logic [1:0]  pair_register_code;
    logic [4:0]  table_wr_index, src_reg_index, dst_reg_index;
    logic [7:0]  relative_displacement, opcode, sfr_offset;
    logic [15:0] immediate_addr, accumulator_pair, table_wr_data, program_counter, sfr_address;
    logic [7:0]  offs [6] = '{8'h00, 8'hCF, 8'hD0, 8'hDF, 8'hE0, 8'hFF};
    int          fails = 0;
    int          checks_done = 0;

    branch_operand_addressing dut (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Valid stays up after the edge so back-to-back offers need no idle cycle
    task automatic go(input logic [3:0] k);
        instr_valid = 1'b1;
        op_kind = k;
        @(posedge clk);
        #1;
    endtask

    task automatic step(input logic [3:0] k, input logic [2:0] len, input logic [7:0] disp,
                        input logic tk, input logic [15:0] imm, input logic [15:0] exp);
        instr_length = len;
        relative_displacement = disp;
        branch_taken = tk;
        immediate_addr = imm;
        go(k);
        chk(program_counter, exp);
    endtask

    task automatic regop(input logic [3:0] k, input logic [1:0] bank, input logic [2:0] code,
                         input logic [4:0] exp, input logic pair);
        {bank_select_high, bank_select_low} = bank;
        byte_register_code = code;
        pair_register_code = code[1:0];
        go(k);
        chk({11'h0, dst_reg_index}, {11'h0, exp});
        chk({11'h0, src_reg_index}, {11'h0, (k == 4'h6) ? {bank, 3'h1} : exp});
        chk({15'h0, dst_is_pair}, {15'h0, pair});
    endtask

    task automatic sfr(input logic [7:0] off);
        logic bad;
        bad = off[7:4] == 4'hD;
        sfr_offset = off;
        go(4'hC);
        chk({14'h0, sfr_address_valid, sfr_address_fault}, {14'h0, !bad, bad});
        if (!bad) chk(sfr_address, {8'hFF, off});
    endtask

    // Offers made while busy must be dropped; a stray opcode bit must not move the slot
    task automatic table_scenario();
        instr_valid = 1'b0;
        table_wr_en = 1'b1;
        table_wr_index = 5'h1F;
        table_wr_data = 16'hBEEF;
        @(posedge clk);
        #1;
        table_wr_index = 5'h00;
        table_wr_data = 16'h1234;
        @(posedge clk);
        #1;
        table_wr_en = 1'b0;
        opcode = 8'h3E;
        go(4'h4);
        immediate_addr = 16'h5555;
        op_kind = 4'h2;
        chk({15'h0, busy}, 16'h0001);
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
        chk(program_counter, 16'hBEEF);
        chk({busy, pc_loaded}, 16'h0001);
        opcode = 8'h41;
        go(4'h4);
        instr_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(program_counter, 16'h1234);
    endtask

    initial begin
        {reset_n, instr_valid, branch_taken, table_wr_en, bank_select_low, bank_select_high} = '0;
        {op_kind, instr_length, byte_register_code, pair_register_code, table_wr_index} = '0;
        {relative_displacement, opcode, sfr_offset, immediate_addr, table_wr_data} = '0;
        accumulator_pair = 16'hA55A;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk(program_counter, 16'h0000);
        step(4'h0, 3'h3, 8'h00, 1'b0, 16'h0000, 16'h0003);
        step(4'h0, 3'h7, 8'h00, 1'b0, 16'h0000, 16'h000A);
        step(4'hD, 3'h1, 8'h00, 1'b0, 16'h0000, 16'h000B);
        step(4'h1, 3'h2, 8'h80, 1'b1, 16'h0000, 16'hFF8D);
        step(4'h1, 3'h2, 8'h7F, 1'b1, 16'h0000, 16'h000E);
        step(4'h1, 3'h2, 8'h7F, 1'b0, 16'h0000, 16'h0010);
        step(4'h2, 3'h3, 8'h00, 1'b0, 16'h1234, 16'h1234);
        step(4'h3, 3'h3, 8'h00, 1'b0, 16'hFFFF, 16'h0FFF);
        step(4'h3, 3'h3, 8'h00, 1'b0, 16'h0000, 16'h0800);
        step(4'h5, 3'h1, 8'h00, 1'b0, 16'h0000, 16'hA55A);
        table_scenario();
        for (int i = 0; i < 8; i++) regop(4'hA, i[1:0], i[2:0], {i[1:0], i[2:0]}, 1'b0);
        for (int i = 0; i < 4; i++) regop(4'hB, ~i[1:0], i[2:0], {~i[1:0], i[1:0], 1'b0}, 1'b1);
        regop(4'h6, 2'h2, 3'h5, 5'h10, 1'b1);
        regop(4'h7, 2'h1, 3'h5, 5'h08, 1'b1);
        regop(4'h8, 2'h3, 3'h0, 5'h19, 1'b0);
        regop(4'h9, 2'h0, 3'h7, 5'h01, 1'b0);
        foreach (offs[i]) sfr(offs[i]);
        reset_n = 1'b0;
        @(posedge clk);
        #1;
        chk(program_counter, 16'h0000);
        give_verdict();
    end

    initial begin
        #20000;
        fails++;
        give_verdict();
    end
endmodule // branch_operand_addressing_tb
`default_nettype wire
